// ===== include/lcd_host_pkg.sv
`default_nettype none
package lcd_host_pkg;
  // graphic memory geometry
  localparam int GRAPH_ROWS        = 64;
  localparam int GRAPH_COLS        = 256;
  localparam int GRAPH_WORDS_ROW   = GRAPH_COLS / 16;
  localparam int GRAPH_ADDR_W      = 10;
  // driver geometry
  localparam int COMMON_COUNT      = 33;
  localparam int SEGMENT_COUNT     = 64;
  // user font and icon memories
  localparam int FONT_ROW_W        = 4;
  localparam int FONT_SET_LSB      = 4;
  localparam int FONT_ADDR_W       = 6;
  localparam int FONT_CURSOR_ROW   = 15;
  localparam int ICON_ADDR_W       = 4;
  localparam int WORD_W            = 16;
  // serial framing
  localparam int SYNC_ONES         = 5;
  localparam int BITS_PER_SECTION  = 8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // instruction encodings, function set carries bus width in bit 4
  localparam int FUNC_SET_BIT      = 5;
  localparam int BUS_WIDTH_BIT     = 4;
  localparam logic [7:0] SET_GRAPH_ADDR = 8'h80;
  localparam logic [7:0] SET_TEXT_ADDR  = 8'h80;
  localparam logic [6:0] POINTER_RESET  = 7'h00;
  // busy time after each accepted instruction or data byte
  localparam int BUSY_NS           = 72000;
  localparam int CLK_NS            = 25;
  localparam int BUSY_CYCLES       = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUFFER_DEPTH      = 2;

  typedef struct packed {
    logic       isData;
    logic [7:0] value;
  } hostByte_t;

  typedef struct packed {
    logic [GRAPH_ADDR_W-1:0] addr;
    logic [WORD_W-1:0]       word;
  } graphWrite_t;

  typedef enum logic [3:0] {
    SER_HUNT = 4'b0001,
    SER_HEAD = 4'b0010,
    SER_HIGH = 4'b0100,
    SER_LOW  = 4'b1000
  } serState_t;
endpackage
`default_nettype wire

// ===== rtl/lcd_host_interface.sv
// Notes on behaviour
// R1: graphic memory is 64 rows by 256 bits, written as 16-bit words.
// R2: host sends vertical address, horizontal address, then high and low data byte.
// R3: pointer advances by one after each complete two-byte graphic word.
// R4: 33 commons, 64 segments; font data shifted into a 64-bit latch.
// R5: character code bits 1 and 2 become user font address bits 4 and 5.
// R6: font address bits 0 to 3 pick a row; last row is ORed with cursor.
// R7: each user font address holds one 16-bit row.
// R8: user font codes have bits 4 to 15 zero; bits 0 and 3 are ignored.
// R9: icon memory has 4-bit address; bit 15 drives lowest segment of group.
// R10: select pin high means parallel; bus width bit picks 8 or 4 bits.
// R11: 4-bit mode sends high nibble first, both on lines 7..4.
// R12: select pin low means serial, using chip select, serial clock and data.
// R13: serial link is write only.
// R14: serial clock edges count only while chip select is high.
// R15: chip select low clears serial counter and partial data.
// R16: a lone host holds chip select high.
// R17: serial clock is asynchronous and synchronised inside.
// R18: host waits for the previous instruction to finish.
// R19: serial transfer opens with five ones, then read/write, select, zero fill.
// R20: each byte goes as high nibble plus four zeros, then low nibble plus zeros.
// R21: select and direction choose instruction, status, data write or data read.
// R22: busy indicator high rejects new instructions.
// R23: status read drives the address pointer onto lines 6..0.
// R24: serial bits sampled on rising serial clock, most significant first.
// R25: parallel writes latch on strobe fall; reads drive only while strobe high.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_interface (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  input  wire logic        interfaceSelectPin,
  input  wire logic        registerSelect,
  input  wire logic        readNotWrite,
  input  wire logic        strobe,
  input  wire logic [7:0]  dataLinesIn,
  output logic      [7:0]  dataLinesOut,
  output logic             dataLinesOe,
  input  wire logic        chipSelect,
  input  wire logic        serialClock,
  input  wire logic        serialDataIn,
  input  wire logic        graphicMode,
  input  wire logic [15:0] charCode,
  input  wire logic [3:0]  fontRow,
  input  wire logic [15:0] cursorPattern,
  input  wire logic [15:0] fontRomRow,
  input  wire logic        segShiftEn,
  input  wire logic        segLoad,
  output logic      [63:0] segmentLatch,
  output logic      [15:0] fontRowOut,
  output logic      [15:0] iconWord,
  input  wire logic [3:0]  iconAddr,
  output logic             busyIndicator,
  output logic             busWidth8,
  output logic      [6:0]  addressPointer,
  output logic             graphWriteValid,
  input  wire logic        graphWriteReady,
  output lcd_host_pkg::graphWrite_t graphWrite
);
  // two-flop synchronisers for every pin
  logic [1:0] selS_q, rsS_q, rwS_q, stbS_q, csS_q, sckS_q, sdS_q;
  logic [7:0] dbS1_q, dbS2_q;
  logic       stbOld_q, sckOld_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {selS_q, rsS_q, rwS_q, stbS_q, csS_q, sckS_q, sdS_q} <= '0;
      dbS1_q   <= 8'h00;
      dbS2_q   <= 8'h00;
      stbOld_q <= 1'b0;
      sckOld_q <= 1'b0;
    end else if (clkEn) begin
      selS_q   <= {selS_q[0], interfaceSelectPin};
      rsS_q    <= {rsS_q[0], registerSelect};
      rwS_q    <= {rwS_q[0], readNotWrite};
      stbS_q   <= {stbS_q[0], strobe};
      csS_q    <= {csS_q[0], chipSelect};
      sckS_q   <= {sckS_q[0], serialClock};
      sdS_q    <= {sdS_q[0], serialDataIn};
      dbS1_q   <= dataLinesIn;
      dbS2_q   <= dbS1_q;
      stbOld_q <= stbS_q[1];
      sckOld_q <= sckS_q[1];
    end
  end
  logic parMode, strobeFall, sckRise;
  // R10: select pin picks parallel
  assign parMode    = selS_q[1];
  // R25: write latched on strobe fall
  assign strobeFall = stbOld_q & ~stbS_q[1] & parMode;
  // R14: edges only with chip select
  // R24: rising serial edge samples
  assign sckRise    = sckS_q[1] & ~sckOld_q & ~parMode & csS_q[1];

  // byte assembly: parallel and serial
  lcd_host_pkg::serState_t serSt_q, serSt_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] nibHi_q, nibHi_d;
  logic       serRs_q, serRs_d;
  logic       parNib_q, parNib_d;
  logic       byteValid;
  lcd_host_pkg::hostByte_t byteIn;
  logic       busWidth_q, busWidth_d;
  always_comb begin
    serSt_d   = serSt_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    nibHi_d   = nibHi_q;
    serRs_d   = serRs_q;
    parNib_d  = parNib_q;
    byteValid = 1'b0;
    byteIn    = '{isData: rsS_q[1], value: dbS2_q};
    if (parMode) begin
      serSt_d  = lcd_host_pkg::SER_HUNT;
      bitCnt_d = 3'd0;
      // R21: reads never enter the write path
      if (strobeFall && !rwS_q[1]) begin
        if (busWidth_q) begin
          byteValid = 1'b1;
        end else if (!parNib_q) begin
          // R11: high nibble first on lines 7..4
          nibHi_d  = dbS2_q[7:4];
          parNib_d = 1'b1;
        end else begin
          byteIn.value = {nibHi_q, dbS2_q[7:4]};
          byteValid    = 1'b1;
          parNib_d     = 1'b0;
        end
      end
    end else if (!csS_q[1]) begin
      // R15: chip select low resets counter
      serSt_d  = lcd_host_pkg::SER_HUNT;
      bitCnt_d = 3'd0;
      shift_d  = 8'h00;
    end else if (sckRise) begin
      shift_d  = {shift_q[6:0], sdS_q[1]};
      bitCnt_d = bitCnt_q + 3'd1;
      case (serSt_q)
        lcd_host_pkg::SER_HUNT: begin
          bitCnt_d = 3'd0;
        end
        lcd_host_pkg::SER_HEAD: begin
          if (bitCnt_q == 3'd6) begin
            serRs_d = sdS_q[1];
          end
          if (bitCnt_q == 3'd7) begin
            // R13: a read request is dropped
            serSt_d = shift_q[1] ? lcd_host_pkg::SER_HUNT : lcd_host_pkg::SER_HIGH;
          end
        end
        lcd_host_pkg::SER_HIGH: begin
          // R20: nibble then four zeros
          if (bitCnt_q == 3'd7) begin
            nibHi_d = shift_q[6:3];
            serSt_d = lcd_host_pkg::SER_LOW;
          end
        end
        lcd_host_pkg::SER_LOW: begin
          if (bitCnt_q == 3'd7) begin
            byteIn    = '{isData: serRs_q, value: {nibHi_q, shift_q[6:3]}};
            byteValid = 1'b1;
            serSt_d   = lcd_host_pkg::SER_HIGH;
          end
        end
        default: serSt_d = lcd_host_pkg::SER_HUNT;
      endcase
      // R19: five ones resynchronise
      // framed sections hold at most four ones in a row, so no false start
      if (serSt_q != lcd_host_pkg::SER_HEAD && &{shift_q[3:0], sdS_q[1]}) begin
        serSt_d   = lcd_host_pkg::SER_HEAD;
        bitCnt_d  = 3'(lcd_host_pkg::SYNC_ONES);
        byteValid = 1'b0;
      end
    end
  end

  // two-entry buffer between byte assembly and execution
  lcd_host_pkg::hostByte_t buf_q [lcd_host_pkg::BUFFER_DEPTH];
  lcd_host_pkg::hostByte_t buf_d [lcd_host_pkg::BUFFER_DEPTH];
  logic [1:0] cnt_q, cnt_d;
  logic       bufReady, bufValid, popByte;
  assign bufReady = cnt_q != 2'd2;
  assign bufValid = cnt_q != 2'd0;
  always_comb begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (popByte) begin
      buf_d[0] = buf_q[1];
      cnt_d    = cnt_d - 2'd1;
    end
    if (byteValid && bufReady) begin
      buf_d[cnt_d[0]] = byteIn;
      cnt_d           = cnt_d + 2'd1;
    end
  end

  // execution: instruction, pointer, graphic words, busy
  logic [6:0]  ptr_q, ptr_d;
  logic        grMode_q, grMode_d;
  logic [1:0]  grStep_q, grStep_d;
  logic [5:0]  grY_q, grY_d;
  logic [3:0]  grX_q, grX_d;
  logic [7:0]  hiByte_q, hiByte_d;
  logic        gwValid_q, gwValid_d;
  lcd_host_pkg::graphWrite_t gw_q, gw_d;
  logic [11:0] busy_q, busy_d;
  lcd_host_pkg::hostByte_t cur;
  assign cur     = buf_q[0];
  // R22: busy holds off the next byte
  // R18: no deeper queue than the buffer
  assign popByte = bufValid && busy_q == 12'd0 && !gwValid_q;
  always_comb begin
    ptr_d      = ptr_q;
    grMode_d   = grMode_q;
    grStep_d   = grStep_q;
    grY_d      = grY_q;
    grX_d      = grX_q;
    hiByte_d   = hiByte_q;
    busWidth_d = busWidth_q;
    gwValid_d  = gwValid_q && !graphWriteReady;
    gw_d       = gw_q;
    busy_d     = (busy_q != 12'd0) ? busy_q - 12'd1 : busy_q;
    if (popByte) begin
      busy_d = 12'(lcd_host_pkg::BUSY_CYCLES);
      if (!cur.isData) begin
        if (cur.value[7:6] == 2'b00 && cur.value[lcd_host_pkg::FUNC_SET_BIT]) begin
          busWidth_d = cur.value[lcd_host_pkg::BUS_WIDTH_BIT];
        end else if (cur.value[7] && graphicMode) begin
          // R2: vertical then horizontal address
          if (grStep_q == 2'd0) begin
            grY_d    = cur.value[5:0];
            grStep_d = 2'd1;
          end else begin
            grX_d    = cur.value[3:0];
            grStep_d = 2'd2;
          end
          grMode_d = 1'b1;
        end else if (cur.value[7]) begin
          ptr_d    = cur.value[6:0];
          grMode_d = 1'b0;
          grStep_d = 2'd0;
        end
      end else if (grMode_q) begin
        if (grStep_q != 2'd3) begin
          hiByte_d = cur.value;
          grStep_d = 2'd3;
        end else begin
          // R1: 64 rows of 16 words
          gw_d      = '{addr: {grY_q, grX_q}, word: {hiByte_q, cur.value}};
          gwValid_d = 1'b1;
          // R3: advance after full word
          grX_d     = grX_q + 4'd1;
          grStep_d  = 2'd2;
        end
      end else begin
        ptr_d = ptr_q + 7'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serSt_q    <= lcd_host_pkg::SER_HUNT;
      bitCnt_q   <= 3'd0;
      shift_q    <= 8'h00;
      nibHi_q    <= 4'h0;
      serRs_q    <= 1'b0;
      parNib_q   <= 1'b0;
      buf_q      <= '{default: '0};
      cnt_q      <= 2'd0;
      ptr_q      <= lcd_host_pkg::POINTER_RESET;
      grMode_q   <= 1'b0;
      grStep_q   <= 2'd0;
      grY_q      <= 6'h00;
      grX_q      <= 4'h0;
      hiByte_q   <= 8'h00;
      busWidth_q <= 1'b1;
      gwValid_q  <= 1'b0;
      gw_q       <= '0;
      busy_q     <= 12'h000;
    end else if (clkEn) begin
      serSt_q    <= serSt_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      nibHi_q    <= nibHi_d;
      serRs_q    <= serRs_d;
      parNib_q   <= parNib_d;
      buf_q      <= buf_d;
      cnt_q      <= cnt_d;
      ptr_q      <= ptr_d;
      grMode_q   <= grMode_d;
      grStep_q   <= grStep_d;
      grY_q      <= grY_d;
      grX_q      <= grX_d;
      hiByte_q   <= hiByte_d;
      busWidth_q <= busWidth_d;
      gwValid_q  <= gwValid_d;
      gw_q       <= gw_d;
      busy_q     <= busy_d;
    end
  end

  // user font and icon memories, written by data bytes outside graphic mode
  logic [15:0] font_q [64];
  logic [15:0] icon_q [16];
  logic [7:0]  memHi_q;
  logic        memHalf_q;
  logic [5:0]  fontAddr;
  // R5: code bits 2:1 become set bits
  // R8: other code bits ignored here
  assign fontAddr = {charCode[2:1], fontRow};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      font_q    <= '{default: 16'h0000};
      icon_q    <= '{default: 16'h0000};
      memHi_q   <= 8'h00;
      memHalf_q <= 1'b0;
    end else if (clkEn && popByte && cur.isData && !grMode_q) begin
      memHalf_q <= !memHalf_q;
      memHi_q   <= cur.value;
      // R7: one 16-bit row per address
      if (memHalf_q) begin
        font_q[ptr_q[5:0]] <= {memHi_q, cur.value};
        icon_q[ptr_q[3:0]] <= {memHi_q, cur.value};
      end
    end
  end

  // R4: 64-bit segment latch
  logic [63:0] seg_q, seg_d;
  logic [15:0] row_q, row_d, pickRow;
  always_comb begin
    // R6: cursor row ORed with pattern
    pickRow = font_q[fontAddr];
    if (fontRow == 4'(lcd_host_pkg::FONT_CURSOR_ROW)) begin
      pickRow = pickRow | cursorPattern;
    end
    row_d = (charCode[15:4] == 12'h000) ? pickRow : fontRomRow;
    seg_d = seg_q;
    if (segLoad) begin
      seg_d = {seg_q[47:0], row_q};
    end else if (segShiftEn) begin
      seg_d = {seg_q[62:0], 1'b0};
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_q   <= 64'h0;
      row_q   <= 16'h0000;
      iconWord <= 16'h0000;
    end else if (clkEn) begin
      seg_q   <= seg_d;
      row_q   <= row_d;
      // R9: bit 15 drives lowest segment
      iconWord <= icon_q[iconAddr];
    end
  end

  // R23: status read drives pointer
  // R25: read lines only while strobe high
  logic [7:0] rdData_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      rdData_q <= rsS_q[1] ? font_q[ptr_q[5:0]][15:8] : {busy_q != 12'd0, ptr_q};
    end
  end
  // R12: serial mode never drives lines
  assign dataLinesOe     = parMode & rwS_q[1] & stbS_q[1];
  assign dataLinesOut    = rdData_q;
  assign segmentLatch    = seg_q;
  assign fontRowOut      = row_q;
  assign busyIndicator   = busy_q != 12'd0;
  assign busWidth8       = busWidth_q;
  assign addressPointer  = ptr_q;
  assign graphWriteValid = gwValid_q;
  assign graphWrite      = gw_q;

  // R3: pointer step after word
  a_graph_advance: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && popByte && cur.isData && grMode_q && grStep_q == 2'd3 |=> grX_q == $past(grX_q) + 4'd1)
    else $error("graphic pointer did not advance");
  // R15: chip select clears counter
  a_cs_clear: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !parMode && !csS_q[1] |=> bitCnt_q == 3'd0 && serSt_q == lcd_host_pkg::SER_HUNT)
    else $error("serial counter kept while deselected");
  // R25: no drive with strobe low
  a_read_drive: assert property (@(posedge clk) disable iff (!nrst)
    !stbS_q[1] |-> !dataLinesOe) else $error("lines driven with strobe low");
  // R22: busy blocks popping
  a_busy_block: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && popByte |=> busyIndicator && !popByte) else $error("busy missing after a byte");
  // R13: serial never drives
  a_serial_silent: assert property (@(posedge clk) disable iff (!nrst)
    !parMode |-> !dataLinesOe) else $error("serial mode drove data lines");
  // R14: no serial shift while deselected
  a_cs_gate: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && !csS_q[1] && !parMode |=> shift_q == 8'h00) else $error("shift while deselected");
  // R6: cursor row includes pattern
  a_cursor_or: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && charCode[15:4] == 12'h000 && fontRow == 4'hf |=> (row_q & $past(cursorPattern)) == $past(cursorPattern))
    else $error("cursor pattern missing");
  // R11: nibble pair forms byte
  a_nibble_pair: assert property (@(posedge clk) disable iff (!nrst)
    clkEn && parMode && !busWidth_q && strobeFall && !rwS_q[1] && parNib_q |-> byteValid)
    else $error("second nibble lost");
endmodule
`default_nettype wire

// ===== tb/lcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input  wire logic       clk,
  input  wire logic       busyIndicator,
  input  wire logic [7:0] dataLinesOut,
  input  wire logic       dataLinesOe,
  output logic            registerSelect,
  output logic            readNotWrite,
  output logic            strobe,
  output logic      [7:0] dataLinesIn,
  output logic            chipSelect,
  output logic            serialClock,
  output logic            serialDataIn
);
  initial begin
    registerSelect = 1'b0;
    readNotWrite = 1'b0;
    strobe = 1'b0;
    dataLinesIn = 8'h00;
    chipSelect = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // poll busy before the next byte
  task automatic waitIdle();
    int k;
    k = 0;
    tick(8);
    while (busyIndicator !== 1'b0 && k < 4000) begin
      tick(1);
      k++;
    end
  endtask

  task automatic parCycle(input logic rs, input logic [7:0] d);
    registerSelect = rs;
    readNotWrite = 1'b0;
    dataLinesIn = d;
    tick(1);
    strobe = 1'b1;
    tick(4);
    strobe = 1'b0;
    tick(4);
    dataLinesIn = ~d;
    tick(1);
  endtask

  // high nibble first on lines 7..4, low lines carry junk
  task automatic parWrite(input logic rs, input logic [7:0] d, input logic nib, input logic hold);
    if (nib) begin
      parCycle(rs, {d[7:4], ~d[7:4]});
      parCycle(rs, {d[3:0], ~d[3:0]});
    end else begin
      parCycle(rs, d);
    end
    if (hold) waitIdle();
  endtask

  task automatic parRead(output logic [7:0] q, output logic oeHi, output logic oeLo);
    registerSelect = 1'b0;
    readNotWrite = 1'b1;
    tick(1);
    strobe = 1'b1;
    tick(6);
    q = dataLinesOut;
    oeHi = dataLinesOe;
    strobe = 1'b0;
    tick(6);
    oeLo = dataLinesOe;
    readNotWrite = 1'b0;
    tick(1);
  endtask

  // msb first, 200 ns clock only inside frames
  task automatic serBits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serialDataIn = b[i];
      tick(4);
      serialClock = 1'b1;
      tick(4);
      serialClock = 1'b0;
    end
    serialDataIn = ~serialDataIn;
    tick(1);
  endtask

  // start byte then two nibble sections
  task automatic serWrite(input logic rs, input logic [7:0] d);
    serBits({5'h1f, 1'b0, rs, 1'b0});
    serBits({d[7:4], 4'h0});
    serBits({d[3:0], 4'h0});
    waitIdle();
  endtask

  // drop select mid byte, then clock ones while deselected
  task automatic serAbort(input logic [7:0] d);
    serBits({5'h1f, 3'b000});
    serBits({d[7:4], 4'h0});
    chipSelect = 1'b0;
    tick(4);
    serBits(8'hff);
    chipSelect = 1'b1;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ===== tb/lcd_host_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_host_interface_tb;
  logic                      clk;
  logic                      nrst;
  logic                      clkEn;
  logic [3:0]                fontRow;
  logic [15:0]               cursorPattern;
  logic                      segShiftEn;
  logic [3:0]                iconAddr;
  logic                      interfaceSelectPin;
  logic                      graphicMode;
  logic                      graphWriteReady;
  logic                      segLoad;
  logic [15:0]               charCode;
  logic [15:0]               fontRomRow;
  logic                      registerSelect;
  logic                      readNotWrite;
  logic                      strobe;
  logic [7:0]                dataLinesIn;
  logic [7:0]                dataLinesOut;
  logic                      dataLinesOe;
  logic                      chipSelect;
  logic                      serialClock;
  logic                      serialDataIn;
  logic [63:0]               segmentLatch;
  logic [15:0]               fontRowOut;
  logic [15:0]               iconWord;
  logic                      busyIndicator;
  logic                      busWidth8;
  logic [6:0]                addressPointer;
  logic                      graphWriteValid;
  lcd_host_pkg::graphWrite_t graphWrite;
  int                        n_mismatch;
  int                        tests_run;

  lcd_host_interface i_dut (
    .clk(clk), .nrst(nrst), .clkEn(clkEn), .interfaceSelectPin(interfaceSelectPin),
    .registerSelect(registerSelect), .readNotWrite(readNotWrite), .strobe(strobe),
    .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
    .chipSelect(chipSelect), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .graphicMode(graphicMode), .charCode(charCode), .fontRow(fontRow), .cursorPattern(cursorPattern),
    .fontRomRow(fontRomRow), .segShiftEn(segShiftEn), .segLoad(segLoad), .segmentLatch(segmentLatch),
    .fontRowOut(fontRowOut), .iconWord(iconWord), .iconAddr(iconAddr), .busyIndicator(busyIndicator),
    .busWidth8(busWidth8), .addressPointer(addressPointer), .graphWriteValid(graphWriteValid),
    .graphWriteReady(graphWriteReady), .graphWrite(graphWrite)
  );

  lcd_host_model i_host (
    .clk(clk), .busyIndicator(busyIndicator), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
    .registerSelect(registerSelect), .readNotWrite(readNotWrite), .strobe(strobe),
    .dataLinesIn(dataLinesIn), .chipSelect(chipSelect), .serialClock(serialClock),
    .serialDataIn(serialDataIn)
  );

  always #12.5 clk = ~clk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // word stays offered through a stall, then leaves after one ready edge
  task automatic takeWord(input logic [25:0] exp);
    i_host.tick(20);
    check(graphWriteValid, 1'b1);
    check(graphWrite, exp);
    graphWriteReady = 1'b1;
    i_host.tick(1);
    graphWriteReady = 1'b0;
    i_host.tick(1);
    check(graphWriteValid, 1'b0);
  endtask

  task automatic testReset();
    check({busWidth8, busyIndicator, graphWriteValid, dataLinesOe}, 4'h8);
    check(addressPointer, 7'h00);
  endtask

  task automatic testGraphic();
    graphicMode = 1'b1;
    i_host.parWrite(1'b0, 8'ha5, 1'b0, 1'b1);
    i_host.parWrite(1'b0, 8'h8e, 1'b0, 1'b1);
    i_host.parWrite(1'b1, 8'ha5, 1'b0, 1'b1);
    i_host.parWrite(1'b1, 8'h3c, 1'b0, 1'b1);
    takeWord({6'h25, 4'he, 16'ha53c});
    i_host.parWrite(1'b1, 8'h12, 1'b0, 1'b1);
    i_host.parWrite(1'b1, 8'h34, 1'b0, 1'b1);
    takeWord({6'h25, 4'hf, 16'h1234});
    graphicMode = 1'b0;
  endtask

  // four bytes back to back: one runs, two wait, the last is dropped
  task automatic testBuffer();
    for (int i = 1; i <= 4; i++) begin
      i_host.parWrite(1'b0, 8'h80 | 8'(i), 1'b0, 1'b0);
    end
    check(busyIndicator, 1'b1);
    i_host.tick(3 * lcd_host_pkg::BUSY_CYCLES + 100);
    check({busyIndicator, addressPointer}, 8'h03);
  endtask

  task automatic testSerial();
    interfaceSelectPin = 1'b0;
    i_host.tick(6);
    i_host.serWrite(1'b0, 8'h85);
    check(addressPointer, 7'h05);
    i_host.serAbort(8'hc7);
    check(addressPointer, 7'h05);
    i_host.serWrite(1'b1, 8'h55);
    check(addressPointer, 7'h06);
    i_host.serWrite(1'b1, 8'h66);
    check(addressPointer, 7'h07);
    check(dataLinesOe, 1'b0);
  endtask

  task automatic testStatus();
    logic [7:0] q;
    logic       oeHi;
    logic       oeLo;
    interfaceSelectPin = 1'b1;
    i_host.tick(6);
    i_host.parRead(q, oeHi, oeLo);
    check({oeHi, oeLo, q[6:0]}, {2'b10, 7'h07});
  endtask

  task automatic testNibble();
    i_host.parWrite(1'b0, 8'h20, 1'b0, 1'b1);
    check(busWidth8, 1'b0);
    i_host.parWrite(1'b0, 8'h8a, 1'b1, 1'b1);
    check(addressPointer, 7'h0a);
  endtask

  // rom code passes the rom row, user codes read the font flops
  task automatic testFont();
    charCode = 16'ha140;
    fontRomRow = 16'h5a3c;
    i_host.tick(6);
    check(fontRowOut, 16'h5a3c);
    segLoad = 1'b1;
    i_host.tick(1);
    segLoad = 1'b0;
    check(segmentLatch, 64'h5a3c);
    charCode = 16'h0000;
    fontRow = 4'hf;
    i_host.tick(2);
    check(fontRowOut, 16'h00ff);
    segLoad = 1'b1;
    i_host.tick(1);
    segLoad = 1'b0;
    check(segmentLatch, 64'h5a3c00ff);
    clkEn = 1'b0;
    segShiftEn = 1'b1;
    i_host.tick(4);
    check(segmentLatch, 64'h5a3c00ff);
    clkEn = 1'b1;
    i_host.tick(4);
    segShiftEn = 1'b0;
    check(segmentLatch, 64'h5a3c00ff0);
    // pair 55 66 landed at pointer 6
    charCode = 16'h0009;
    fontRow = 4'h6;
    iconAddr = 4'h6;
    i_host.tick(2);
    check(fontRowOut, 16'h5566);
    check(iconWord, 16'h5566);
    charCode = 16'h0006;
    i_host.tick(2);
    check(fontRowOut, 16'h0000);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    clkEn = 1'b1;
    fontRow = 4'h3;
    cursorPattern = 16'h00ff;
    segShiftEn = 1'b0;
    iconAddr = 4'h2;
    interfaceSelectPin = 1'b1;
    graphicMode = 1'b0;
    graphWriteReady = 1'b0;
    segLoad = 1'b0;
    charCode = 16'h0000;
    fontRomRow = 16'h0000;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    #2;
    nrst = 1'b1;
    i_host.tick(6);
    testReset();
    testGraphic();
    testBuffer();
    testSerial();
    testStatus();
    testNibble();
    testFont();
    summarize();
  end

  // run needs about 1.0 ms of busy time
  initial begin
    #2ms;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
